/* pkg/nsid_pkg.sv */
// nsid_pkg: layout, offsets and types for the namespace identify field bank
// assumes one clock domain and a synchronous active-high reset
package nsid_pkg;

  // byte offsets in the namespace identify structure
  localparam logic [7:0] OFF_NAMESPACE_SIZE         = 8'h00;
  localparam logic [7:0] OFF_NAMESPACE_CAPACITY     = 8'h08;
  localparam logic [7:0] OFF_NAMESPACE_UTILIZATION  = 8'h10;
  localparam logic [7:0] OFF_NAMESPACE_FEATURE_BITS = 8'h18;
  localparam logic [7:0] OFF_BLOCK_FORMAT_COUNT     = 8'h19;
  localparam logic [7:0] OFF_FORMATTED_BLOCK_FORMAT = 8'h1a;
  localparam logic [7:0] OFF_METADATA_CAPABILITIES  = 8'h1b;
  localparam logic [7:0] OFF_FORMAT_TABLE_FIRST     = 8'h80;
  localparam logic [7:0] OFF_FORMAT_TABLE_LAST      = 8'hbf;

  // field positions
  localparam int FEAT_THIN_BIT     = 0;
  localparam int FEAT_ATOMIC_BIT   = 1;
  localparam int FEAT_DEALLOC_BIT  = 2;
  localparam int FMT_INDEX_MSB     = 3;
  localparam int FMT_EXTENDED_BIT  = 4;
  localparam int MC_EXTENDED_BIT   = 0;
  localparam int MC_SEPARATE_BIT   = 1;
  localparam int MAX_FORMATS       = 16;

  // reset values
  localparam logic [63:0] RST_COUNT = 64'h0000_0000_0000_0000;
  localparam logic [7:0]  RST_BYTE  = 8'h00;

  // host read request
  typedef struct packed {
    logic       valid;
    logic [7:0] offset;
  } nsid_rd_req_t;

  // format command from the controller
  typedef struct packed {
    logic        valid;
    logic [3:0]  index;
    logic        extended;
    logic [63:0] size;
    logic [63:0] capacity;
  } nsid_fmt_cmd_t;

  // one allocation event: write or write-uncorrectable, or a deallocation
  typedef struct packed {
    logic        valid;
    logic [63:0] first_block;
    logic [15:0] count;
  } nsid_range_t;

  typedef enum logic [2:0] {
    ST_UNFORMATTED = 3'b001,
    ST_FORMATTED   = 3'b010,
    ST_FORMATTING  = 3'b100
  } nsid_state_t;

endpackage

/* src/nsid_alloc_map.sv */
// nsid_alloc_map: one allocated flag per logical block, with change detection
// assumes the block address is below DEPTH; out-of-range ranges are clipped
`timescale 1ns/100ps
`default_nettype none
module nsid_alloc_map
  import nsid_pkg::*;
#(
  parameter int DEPTH = 64
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            clear_all,
  input  wire nsid_range_t     alloc,
  input  wire nsid_range_t     dealloc,
  output logic [DEPTH-1:0]     map_q,
  output logic [15:0]          added,
  output logic [15:0]          removed
);

  initial begin
    if (DEPTH < 1 || DEPTH > 65535) $error("nsid_alloc_map: DEPTH out of range");
  end

  typedef struct packed {
    logic [DEPTH-1:0] map;
  } map_state_t;

  map_state_t state_reg;
  map_state_t state_next;

  function automatic logic in_range(input nsid_range_t r, input int i);
    in_range = r.valid && (64'(i) >= r.first_block)
               && (64'(i) < r.first_block + {48'h0000_0000_0000, r.count});
  endfunction

  always_comb begin
    state_next = state_reg;
    added      = 16'h0000;
    removed    = 16'h0000;
    for (int i = 0; i < DEPTH; i++) begin
      if (clear_all) begin
        state_next.map[i] = 1'b0;
      end else if (in_range(alloc, i)) begin
        // write marks the block allocated [R3]
        if (!state_reg.map[i]) added = added + 16'h0001;
        state_next.map[i] = 1'b1;
      end else if (in_range(dealloc, i)) begin
        // dataset management frees the block [R4]
        if (state_reg.map[i]) removed = removed + 16'h0001;
        state_next.map[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign map_q = state_reg.map;

endmodule
`default_nettype wire

/* src/nsid_fields.sv */
// nsid_fields: read-only namespace identify fields with allocation tracking
// assumes host reads arrive as byte offsets from the identify engine
//
// What this block does
// R1: capacity reports most blocks allocatable, never above size, spares excluded
// R2: capacity in formatted block units, undefined before format
// R3: a normal or uncorrectable write allocates the block
// R4: dataset management deallocates blocks
// R5: utilization counts allocated blocks, never above capacity
// R6: feature bit 2 flags deallocated-or-unwritten error support; 7:3 reserved
// R7: feature bit 1 says per-namespace atomic sizes are valid
// R8: feature bit 0 is thin provisioning; cleared means capacity equals size
// R9: with thin provisioning and dealloc, deallocations lower utilization
// R10: format count stored zero-based, at most sixteen
// R11: formats packed ascending from index zero without gaps
// R12: format descriptors live at bytes 128 through 191
// R13: metadata travels wholly extended or wholly separate, never split
// R14: recommended block size 4KB up, metadata at least 8 bytes
// R15: format bit 4 selects extended metadata; 7:5 reserved
// R16: format bits 3:0 pick the current block format
// R17: capability bit 1 means separate metadata buffer supported; 7:2 reserved
// R18: capability bit 0 means extended block metadata supported
// R19: size is total block count, addresses zero to n minus one
// R20: all fields read-only; change only by format or allocation
// R21: metadata placement reported only when its capability is set
`timescale 1ns/100ps
`default_nettype none
module nsid_fields
  import nsid_pkg::*;
#(
  parameter int DEPTH        = 64,
  parameter int NUM_FORMATS  = 4,
  parameter bit THIN_PROV    = 1'b1,
  parameter bit ATOMIC_VALID = 1'b0,
  parameter bit DEALLOC_ERR  = 1'b1,
  parameter bit DSM_SUPPORT  = 1'b1,
  parameter bit MC_EXTENDED  = 1'b1,
  parameter bit MC_SEPARATE  = 1'b1
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic [NUM_FORMATS*32-1:0] format_entries,
  input  wire nsid_fmt_cmd_t             fmt_cmd,
  input  wire nsid_range_t               write_done,
  input  wire nsid_range_t               dealloc_req,
  input  wire nsid_rd_req_t              rd_req,
  input  wire logic                      wr_attempt,
  output logic                           rd_valid,
  output logic [7:0]                     rd_data,
  output logic                           fmt_ack,
  output logic                           fmt_reject,
  output logic                           formatted,
  output logic [63:0]                    namespace_size,
  output logic [63:0]                    namespace_capacity,
  output logic [63:0]                    namespace_utilization
);

  initial begin
    if (NUM_FORMATS < 1 || NUM_FORMATS > MAX_FORMATS)
      $error("nsid_fields: NUM_FORMATS must be 1..16");
    if (DEPTH < 1 || DEPTH > 65535)
      $error("nsid_fields: DEPTH out of range");
  end

  typedef struct packed {
    nsid_state_t st;
    logic [63:0] size;
    logic [63:0] capacity;
    logic [63:0] utilization;
    logic [7:0]  fmt_field;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        fmt_ack;
    logic        fmt_reject;
  } fld_state_t;

  fld_state_t state_reg;
  fld_state_t state_next;

  logic [DEPTH-1:0] map_q;
  logic [15:0]      added;
  logic [15:0]      removed;
  logic             clear_all;
  nsid_range_t      alloc_in;
  nsid_range_t      dealloc_in;
  logic [7:0]       table_byte;
  logic             sel_valid;
  logic [31:0]      sel_entry;
  logic [63:0]      depth64;
  logic [15:0]      pop_part [DEPTH+1];
  logic [15:0]      alloc_pop;

  // constant identify bytes
  localparam logic [7:0] FEAT_BYTE = {5'b00000, DEALLOC_ERR, ATOMIC_VALID, THIN_PROV};
  localparam logic [7:0] COUNT_BYTE = 8'(NUM_FORMATS - 1);
  localparam logic [7:0] MC_BYTE = {6'b000000, MC_SEPARATE, MC_EXTENDED};

  function automatic logic [7:0] byte_of(input logic [63:0] v, input logic [2:0] b);
    byte_of = v[{b, 3'b000} +: 8];
  endfunction

  // trim a block range to the namespace, blocks 0..lim-1 [R19]
  function automatic nsid_range_t clip_to_ns(input nsid_range_t r, input logic [63:0] lim);
    logic [63:0] stop;
    clip_to_ns = r;
    stop       = r.first_block + {48'h0000_0000_0000, r.count};
    if (r.first_block >= lim) begin
      clip_to_ns.valid = 1'b0;
    end else if (stop > lim) begin
      clip_to_ns.count = 16'(lim - r.first_block);
    end
  endfunction

  assign depth64 = 64'(DEPTH);

  // allocations only once formatted; deallocations only with dataset management
  always_comb begin
    alloc_in         = clip_to_ns(write_done, state_reg.size);
    alloc_in.valid   = alloc_in.valid && (state_reg.st == ST_FORMATTED)
                       && !fmt_cmd.valid; // [R3]
    dealloc_in       = clip_to_ns(dealloc_req, state_reg.size);
    dealloc_in.valid = dealloc_in.valid && DSM_SUPPORT && !fmt_cmd.valid
                       && (state_reg.st == ST_FORMATTED); // [R4]
    clear_all        = (state_reg.st == ST_FORMATTING);
  end

  nsid_alloc_map #(
    .DEPTH (DEPTH)
  ) u_map (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .clear_all (clear_all),
    .alloc     (alloc_in),
    .dealloc   (dealloc_in),
    .map_q     (map_q),
    .added     (added),
    .removed   (removed)
  );

  nsid_format_table #(
    .NUM_FORMATS (NUM_FORMATS)
  ) u_table (
    .entries   (format_entries),
    .offset    (rd_req.offset),
    .sel_index (fmt_cmd.index),
    .rd_byte   (table_byte),
    .sel_valid (sel_valid),
    .sel_entry (sel_entry)
  );

  // population of the allocation map, one adder stage per block
  assign pop_part[0] = 16'h0000;
  for (genvar g = 0; g < DEPTH; g++) begin : g_pop
    assign pop_part[g+1] = pop_part[g] + {15'h0000, map_q[g]};
  end
  assign alloc_pop = pop_part[DEPTH];

  always_comb begin
    logic [63:0] cap_req;
    logic [63:0] size_req;
    logic        meta_present;
    logic        ext_ok;
    logic [63:0] used;
    cap_req      = 64'h0000_0000_0000_0000;
    size_req     = 64'h0000_0000_0000_0000;
    meta_present = 1'b0;
    ext_ok       = 1'b0;
    used         = 64'h0000_0000_0000_0000;
    state_next            = state_reg;
    state_next.rd_valid   = 1'b0;
    state_next.fmt_ack    = 1'b0;
    state_next.fmt_reject = 1'b0;

    case (state_reg.st)
      ST_UNFORMATTED, ST_FORMATTED: begin
        if (fmt_cmd.valid) begin
          // size clipped to trackable depth; addresses 0..n-1 [R19]
          size_req = (fmt_cmd.size > depth64) ? depth64 : fmt_cmd.size;
          // capacity never above size; equal when not thin [R1] [R8]
          cap_req  = (!THIN_PROV || fmt_cmd.capacity > size_req) ? size_req
                                                                 : fmt_cmd.capacity;
          meta_present = (sel_entry[15:0] != 16'h0000); // [R14]
          // placement must match capabilities, and one placement only [R13] [R21]
          ext_ok = !meta_present
                   || (fmt_cmd.extended ? MC_EXTENDED : MC_SEPARATE);
          if (sel_valid && ext_ok) begin // [R16]
            state_next.st        = ST_FORMATTING;
            state_next.size      = size_req;
            state_next.capacity  = cap_req; // [R2]
            state_next.utilization = RST_COUNT;
            // bit 4 only meaningful with metadata; 7:5 zero [R15] [R16]
            state_next.fmt_field = {3'b000, fmt_cmd.extended && meta_present,
                                    fmt_cmd.index};
          end else begin
            state_next.fmt_reject = 1'b1;
          end
        end else if (state_reg.st == ST_FORMATTED) begin
          // live count of allocated blocks, so saturation cannot drift [R5] [R9]
          used = {48'h0000_0000_0000, alloc_pop} + {48'h0000_0000_0000, added}
                 - {48'h0000_0000_0000, removed};
          state_next.utilization = (used > state_reg.capacity) ? state_reg.capacity
                                                                : used; // [R5]
        end
      end
      ST_FORMATTING: begin
        // map cleared this cycle
        state_next.st      = ST_FORMATTED;
        state_next.fmt_ack = 1'b1;
      end
      default: begin
        state_next.st = ST_UNFORMATTED;
      end
    endcase

    // host read path; host writes are ignored [R20]
    if (rd_req.valid) begin
      state_next.rd_valid = 1'b1;
      if (rd_req.offset < OFF_NAMESPACE_CAPACITY) begin
        state_next.rd_data = byte_of(state_reg.size, rd_req.offset[2:0]); // [R19]
      end else if (rd_req.offset < OFF_NAMESPACE_UTILIZATION) begin
        state_next.rd_data = byte_of(state_reg.capacity, rd_req.offset[2:0]); // [R1]
      end else if (rd_req.offset < OFF_NAMESPACE_FEATURE_BITS) begin
        state_next.rd_data = byte_of(state_reg.utilization, rd_req.offset[2:0]); // [R5]
      end else if (rd_req.offset == OFF_NAMESPACE_FEATURE_BITS) begin
        state_next.rd_data = FEAT_BYTE; // [R6] [R7] [R8]
      end else if (rd_req.offset == OFF_BLOCK_FORMAT_COUNT) begin
        state_next.rd_data = COUNT_BYTE; // [R10]
      end else if (rd_req.offset == OFF_FORMATTED_BLOCK_FORMAT) begin
        state_next.rd_data = state_reg.fmt_field; // [R15] [R16]
      end else if (rd_req.offset == OFF_METADATA_CAPABILITIES) begin
        state_next.rd_data = MC_BYTE; // [R17] [R18]
      end else if (rd_req.offset >= OFF_FORMAT_TABLE_FIRST
                   && rd_req.offset <= OFF_FORMAT_TABLE_LAST) begin
        state_next.rd_data = table_byte; // [R12]
      end else begin
        state_next.rd_data = RST_BYTE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg.st          <= ST_UNFORMATTED;
      state_reg.size        <= RST_COUNT;
      state_reg.capacity    <= RST_COUNT;
      state_reg.utilization <= RST_COUNT;
      state_reg.fmt_field   <= RST_BYTE;
      state_reg.rd_valid    <= 1'b0;
      state_reg.rd_data     <= RST_BYTE;
      state_reg.fmt_ack     <= 1'b0;
      state_reg.fmt_reject  <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_valid              = state_reg.rd_valid;
  assign rd_data               = state_reg.rd_data;
  assign fmt_ack               = state_reg.fmt_ack;
  assign fmt_reject            = state_reg.fmt_reject;
  assign formatted             = (state_reg.st == ST_FORMATTED);
  assign namespace_size        = state_reg.size;
  assign namespace_capacity    = state_reg.capacity;
  assign namespace_utilization = state_reg.utilization;

endmodule
`default_nettype wire

/* src/nsid_format_table.sv */
// nsid_format_table: packed table of supported block formats
// assumes format entries are strapped as constants by the integrator
`timescale 1ns/100ps
`default_nettype none
module nsid_format_table
  import nsid_pkg::*;
#(
  parameter int NUM_FORMATS = 4
) (
  input  wire logic [NUM_FORMATS*32-1:0] entries,
  input  wire logic [7:0]                offset,
  input  wire logic [3:0]                sel_index,
  output logic      [7:0]                rd_byte,
  output logic                           sel_valid,
  output logic      [31:0]               sel_entry
);

  initial begin
    if (NUM_FORMATS < 1 || NUM_FORMATS > MAX_FORMATS)
      $error("nsid_format_table: NUM_FORMATS must be 1..16");
  end

  logic [7:0] rel;
  logic [5:0] word_idx;

  // entries packed from index zero, four bytes each, in 128..191 [R11] [R12]
  always_comb begin
    rel       = offset - OFF_FORMAT_TABLE_FIRST;
    word_idx  = {2'b00, rel[5:2]};
    rd_byte   = 8'h00;
    sel_valid = (int'(sel_index) < NUM_FORMATS);
    sel_entry = 32'h0000_0000;
    if (offset >= OFF_FORMAT_TABLE_FIRST && offset <= OFF_FORMAT_TABLE_LAST
        && int'(word_idx) < NUM_FORMATS) begin
      rd_byte = entries[int'(word_idx)*32 + int'(rel[1:0])*8 +: 8];
    end
    if (sel_valid) begin
      sel_entry = entries[int'(sel_index)*32 +: 32];
    end
  end

endmodule
`default_nettype wire

/* testbench/nsid_fields_checker.sv */
// nsid_fields_checker: port-level checks of the identify field bank
// assumes binding into nsid_fields with the same parameters
`timescale 1ns/100ps
`default_nettype none
module nsid_fields_checker
  import nsid_pkg::*;
#(
  parameter int NUM_FORMATS  = 4,
  parameter bit THIN_PROV    = 1'b1,
  parameter bit ATOMIC_VALID = 1'b0,
  parameter bit DEALLOC_ERR  = 1'b1,
  parameter bit MC_EXTENDED  = 1'b1,
  parameter bit MC_SEPARATE  = 1'b1
) (
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire nsid_fmt_cmd_t fmt_cmd,
  input wire nsid_range_t   write_done,
  input wire nsid_range_t   dealloc_req,
  input wire nsid_rd_req_t  rd_req,
  input wire logic          rd_valid,
  input wire logic [7:0]    rd_data,
  input wire logic          fmt_ack,
  input wire logic          fmt_reject,
  input wire logic          formatted,
  input wire logic [63:0]   namespace_size,
  input wire logic [63:0]   namespace_capacity,
  input wire logic [63:0]   namespace_utilization
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_feat;
    rd_req.valid && rd_req.offset == 8'h18 |=> rd_valid
      && rd_data == {5'h00, DEALLOC_ERR, ATOMIC_VALID, THIN_PROV};
  endproperty
  a_feat: assert property (p_feat) else $error("feature byte wrong");

  property p_count;
    rd_req.valid && rd_req.offset == 8'h19 |=> rd_data == 8'(NUM_FORMATS - 1);
  endproperty
  a_count: assert property (p_count) else $error("format count wrong");

  property p_mcap;
    rd_req.valid && rd_req.offset == 8'h1b |=> rd_data == {6'h00, MC_SEPARATE, MC_EXTENDED};
  endproperty
  a_mcap: assert property (p_mcap) else $error("capability byte wrong");

  property p_formatted_block_format;
    rd_req.valid && rd_req.offset == 8'h1a |=> rd_data[7:5] == 3'h0
      && (!rd_data[4] || MC_EXTENDED);
  endproperty
  a_formatted_block_format: assert property (p_formatted_block_format) else $error("format byte wrong");

  property p_cap;
    namespace_capacity <= namespace_size
      && (THIN_PROV || namespace_capacity == namespace_size);
  endproperty
  a_cap: assert property (p_cap) else $error("capacity above size");

  property p_use;
    namespace_utilization <= namespace_capacity;
  endproperty
  a_use: assert property (p_use) else $error("utilization above capacity");

  property p_alloc;
    formatted && write_done.valid && !dealloc_req.valid && !fmt_cmd.valid
      |=> namespace_utilization >= $past(namespace_utilization);
  endproperty
  a_alloc: assert property (p_alloc) else $error("write lowered utilization");

  property p_dealloc;
    formatted && dealloc_req.valid && !write_done.valid && !fmt_cmd.valid
      |=> namespace_utilization <= $past(namespace_utilization);
  endproperty
  a_dealloc: assert property (p_dealloc) else $error("dealloc raised utilization");

  property p_fmt;
    fmt_cmd.valid |=> fmt_reject or (##1 fmt_ack && formatted);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format not answered");

  property p_hold;
    !fmt_cmd.valid |=> $stable(namespace_capacity) && $stable(namespace_size);
  endproperty
  a_hold: assert property (p_hold) else $error("field changed without format");
endmodule

bind nsid_fields nsid_fields_checker #(
  .NUM_FORMATS(NUM_FORMATS), .THIN_PROV(THIN_PROV), .ATOMIC_VALID(ATOMIC_VALID),
  .DEALLOC_ERR(DEALLOC_ERR), .MC_EXTENDED(MC_EXTENDED), .MC_SEPARATE(MC_SEPARATE)
) i_chk (.ref_clk, .rst, .fmt_cmd, .write_done, .dealloc_req, .rd_req, .rd_valid, .rd_data,
  .fmt_ack, .fmt_reject, .formatted, .namespace_size, .namespace_capacity,
  .namespace_utilization);
`default_nettype wire

/* testbench/tb.sv */
// tb: self-checking bench for the namespace identify field bank
// assumes nsid_fields default parameters and the bound checker
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
  import nsid_pkg::*;
  localparam logic [127:0] ENT = 128'h000a_0004_000b_0002_000c_0008_0009_0000;
  logic          ref_clk     = 1'b0;
  logic          rst         = 1'b1;
  nsid_fmt_cmd_t fmt_cmd     = '0;
  nsid_range_t   write_done  = '0;
  nsid_range_t   dealloc_req = '0;
  nsid_rd_req_t  rd_req      = '0;
  logic          wr_attempt  = 1'b0;
  logic          rd_valid, fmt_ack, fmt_reject, formatted;
  logic [7:0]    rd_data, b;
  logic [63:0]   ns_size, ns_cap, ns_use, v;
  int            error_cnt   = 0;
  int            n_compared  = 0;

  nsid_fields i_dut (
    .ref_clk(ref_clk), .rst(rst), .format_entries(ENT), .fmt_cmd(fmt_cmd),
    .write_done(write_done), .dealloc_req(dealloc_req), .rd_req(rd_req),
    .wr_attempt(wr_attempt), .rd_valid(rd_valid), .rd_data(rd_data), .fmt_ack(fmt_ack),
    .fmt_reject(fmt_reject), .formatted(formatted), .namespace_size(ns_size),
    .namespace_capacity(ns_cap), .namespace_utilization(ns_use));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] off);
    @(posedge ref_clk) rd_req <= '{1'b1, off};
    @(posedge ref_clk) rd_req <= '0;
    #1 `CHK("rd_valid", 1'b1, rd_valid)
    b = rd_data;
  endtask

  task automatic rd64(input logic [7:0] base);
    for (int k = 0; k < 8; k++) begin
      rd(base + 8'(k));
      v[8*k+:8] = b;
    end
  endtask

  task automatic fmt(input logic [3:0] idx, input logic ext, input logic [63:0] sz,
                     input logic [63:0] cap, input logic ok);
    @(posedge ref_clk) fmt_cmd <= '{1'b1, idx, ext, sz, cap};
    @(posedge ref_clk) fmt_cmd <= '0;
    #1 `CHK("fmt_reject", !ok, fmt_reject)
    @(posedge ref_clk) #1 `CHK("fmt_ack", ok, fmt_ack)
  endtask

  task automatic blk(input logic dal, input logic [63:0] first, input logic [15:0] n);
    @(posedge ref_clk) begin
      if (dal) dealloc_req <= '{1'b1, first, n};
      else write_done <= '{1'b1, first, n};
    end
    @(posedge ref_clk) begin
      dealloc_req <= '0;
      write_done <= '0;
    end
    #1;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    #1 `CHK("formatted", 1'b0, formatted)
    `CHK("use", 64'h0, ns_use)
    rd(8'h18); `CHK("features", 8'h05, b)
    rd(8'h19); `CHK("fmt_count", 8'h03, b)
    rd(8'h1b); `CHK("md_caps", 8'h03, b)
    for (int k = 0; k < 16; k++) begin
      rd(8'h80 + 8'(k)); `CHK("fmt_table", ENT[8*k+:8], b)
    end
    rd(8'h90); `CHK("fmt_gap", 8'h00, b)
    $display("test constants done");
    fmt(4'h0, 1'b1, 64'd100, 64'd200, 1'b1);
    `CHK("size_clip", 64'd64, ns_size)
    `CHK("cap_clip", 64'd64, ns_cap)
    rd(8'h1a); `CHK("fmt_nomd", 8'h00, b)
    fmt(4'h1, 1'b1, 64'd40, 64'd32, 1'b1);
    rd(8'h1a); `CHK("fmt_ext", 8'h11, b)
    rd64(8'h08); `CHK("cap_rd", 64'd32, v)
    rd64(8'h00); `CHK("size_rd", 64'd40, v)
    fmt(4'h4, 1'b0, 64'd8, 64'd8, 1'b0); `CHK("kept", 64'd40, ns_size)
    $display("test format done");
    blk(1'b0, 64'd0, 16'd3); `CHK("use_w", 64'd3, ns_use)
    blk(1'b0, 64'd2, 16'd3); `CHK("use_ovl", 64'd5, ns_use)
    blk(1'b1, 64'd0, 16'd2); `CHK("use_d", 64'd3, ns_use)
    rd64(8'h10); `CHK("use_rd", 64'd3, v)
    blk(1'b0, 64'd0, 16'd40); `CHK("use_sat", 64'd32, ns_use)
    @(posedge ref_clk) wr_attempt <= 1'b1;
    @(posedge ref_clk) wr_attempt <= 1'b0;
    rd64(8'h08); `CHK("cap_ro", 64'd32, v)
    blk(1'b1, 64'd0, 16'd10); `CHK("use_live", 64'd30, ns_use)
    fmt(4'h2, 1'b0, 64'd16, 64'd16, 1'b1);
    `CHK("use_fmt", 64'd0, ns_use)
    rd(8'h1a); `CHK("fmt_sep", 8'h02, b)
    blk(1'b0, 64'd10, 16'd20); `CHK("use_clip", 64'd6, ns_use)
    $display("test allocation done");
    summarize();
  end
endmodule
`default_nettype wire
